// ==== hw/two_wire_pad_control.sv ====
// Function
// [R1] slew select 1: bus slew on, general ignored
// [R2] slew select 0: general slew bit drives pad
// [R3] pull-up code 01 double, 10 tenfold
// [R4] pull-up code 00: standard, gated by general
// [R5] threshold 11 smbus3, 10 smbus2, 01 bus
// [R6] threshold 00: standard buffer by input-level bit
// [R7] bit 7 and bits 3-2 read zero
// [R8] implemented fields read/write, reset to zero
// [R9] bus-enabled pins read through schmitt bus input
// [R10] general weak pull-up bit enables pull-up
// [R11] general slew bit limits slew rate
// [R12] general input-level bit selects schmitt else ttl
// [R13] six independent registers, port d pair optional
`include "pad_ctrl_regs.svh"

module two_wire_pad_control #(
   parameter int NUM_PADS = 6,
   parameter bit HAS_PORTD = 1'b1
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pad controls, one entry per pin
   output pad_ctrl_pkg::pad_drive_t pad_drive [NUM_PADS]
);

   ////////////////////////////////////////////////////////////////////////
   // storage

   // one control word per bus-capable pad
   logic [7:0] pad_reg [NUM_PADS];
   logic [7:0] pad_next [NUM_PADS];

   // general per-pin slew, weak pull-up and input-level bits
   logic [31:0] general_reg;
   logic [31:0] general_next;

   // read path
   logic [31:0] prdata_next;
   logic [31:0] rd_hold_reg;

   ////////////////////////////////////////////////////////////////////////
   // bus phase decode

   // only the access phase moves data; the setup phase is ignored
   wire access_phase = psel && penable;
   wire write_en = access_phase && pwrite;
   wire read_en = access_phase && !pwrite;

   ////////////////////////////////////////////////////////////////////////
   // address decode

   // a pad word sits at four times its index; the general word sits just
   // above the last pad slot, so the whole map fits in the low window
   wire word_aligned = (paddr[1:0] == 2'b00);
   wire low_window = (paddr[11:5] == 7'h00);
   wire [2:0] pad_index = paddr[4:2];
   wire index_in_range = (pad_index < 3'(NUM_PADS));

   // smaller variants drop the port d pair; their slots then answer with
   // an error instead of storing into registers that are not there
   wire index_present = HAS_PORTD || (pad_index < 3'h4); // R13

   wire pad_hit = low_window && word_aligned && index_in_range && index_present; // R13
   wire sel_general = (paddr == `OFS_PIN_GENERAL);
   wire mapped = pad_hit || sel_general;

   // one select line per pad keeps every register independent
   wire [NUM_PADS-1:0] pad_sel;

   genvar s;
   generate
      for (s = 0; s < NUM_PADS; s++)
      begin : g_sel
         assign pad_sel[s] = pad_hit && (pad_index == 3'(s)); // R13
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // response

   // zero wait: every access completes in its first access cycle
   assign pready = 1'b1;

   // unmapped accesses are flagged; their writes are dropped and reads
   // return zero
   assign pslverr = access_phase && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // write data shaping

   // unimplemented bits never reach the flops, so they read back as zero
   wire [7:0] pad_wdata = pwdata[7:0] & `PAD_IMPL_MASK; // R7 R8

   // the general word keeps three six-bit fields, one bit per pad
   wire [5:0] gen_slew_wdata = pwdata[`GEN_SLEW_LO +: 6]; // R11
   wire [5:0] gen_wpu_wdata = pwdata[`GEN_WPU_LO +: 6]; // R10
   wire [5:0] gen_inlvl_wdata = pwdata[`GEN_INLVL_LO +: 6]; // R12

   // gaps between the fields stay zero
   wire [31:0] general_wdata =
      {8'h00, 2'b00, gen_inlvl_wdata, 2'b00, gen_wpu_wdata, 2'b00, gen_slew_wdata};

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      for (int i = 0; i < NUM_PADS; i++)
      begin
         pad_next[i] = pad_reg[i];
         if (write_en && pad_sel[i])
         begin
            pad_next[i] = pad_wdata; // R8
         end
      end
   end

   assign general_next = (write_en && sel_general) ? general_wdata : general_reg;

   ////////////////////////////////////////////////////////////////////////
   // read path

   // an out-of-range index never reaches the array read
   wire [7:0] pad_rdata = pad_hit ? pad_reg[pad_index] : 8'h00; // R7

   always_comb
   begin
      prdata_next = 32'h00000000;
      if (read_en && pad_hit)
      begin
         prdata_next = {24'h000000, pad_rdata}; // R7 R8
      end
      else if (read_en && sel_general)
      begin
         prdata_next = general_reg;
      end
   end

   // with no wait state the word must stand in the access cycle itself, so
   // the live term carries it then and a flop holds it afterwards
   assign prdata = read_en ? prdata_next : rd_hold_reg;

   ////////////////////////////////////////////////////////////////////////
   // registers

   // every implemented field clears on any reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < NUM_PADS; i++)
         begin
            pad_reg[i] <= `PAD_RESET; // R8
         end
      end
      else
      begin
         pad_reg <= pad_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         general_reg <= `GEN_RESET;
      end
      else
      begin
         general_reg <= general_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_hold_reg <= 32'h00000000;
      end
      else
      begin
         rd_hold_reg <= prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pad decode

   // purely a function of stored state, so controls follow a write by one
   // cycle and never glitch on bus activity
   genvar g;
   generate
      for (g = 0; g < NUM_PADS; g++)
      begin : g_pad
         pad_field_decode u_decode (
            .ctrl_reg(pad_reg[g]),
            .gen_slew(general_reg[`GEN_SLEW_LO + g]),
            .gen_wpu(general_reg[`GEN_WPU_LO + g]),
            .gen_inlvl(general_reg[`GEN_INLVL_LO + g]),
            .drive(pad_drive[g])
         );
      end
   endgenerate

endmodule

////////////////////////////////////////////////////////////////////////////
// one pad: turns a stored control word and the pin's general bits into
// the analog pad controls

module pad_field_decode (
   // stored pad control word
   input wire logic [7:0] ctrl_reg,
   // general per-pin bits of the same pin
   input wire logic gen_slew,
   input wire logic gen_wpu,
   input wire logic gen_inlvl,
   // analog pad controls
   output pad_ctrl_pkg::pad_drive_t drive
);

   ////////////////////////////////////////////////////////////////////////
   // field extraction

   wire slew_sel = ctrl_reg[`SLEW_SEL_BIT];
   wire [1:0] pu_code = ctrl_reg[`PULLUP_HI:`PULLUP_LO];
   wire [1:0] th_code = ctrl_reg[`THRESH_HI:`THRESH_LO];

   ////////////////////////////////////////////////////////////////////////
   // code decode

   wire pu_std = (pu_code == pad_ctrl_pkg::PU_STANDARD);
   wire pu_double = (pu_code == pad_ctrl_pkg::PU_DOUBLE);
   wire pu_tenfold = (pu_code == pad_ctrl_pkg::PU_TENFOLD);
   wire th_std = (th_code == pad_ctrl_pkg::TH_STANDARD);
   wire th_bus = (th_code == pad_ctrl_pkg::TH_BUS_PAD);
   wire th_smbus2 = (th_code == pad_ctrl_pkg::TH_SMBUS2);
   wire th_smbus3 = (th_code == pad_ctrl_pkg::TH_SMBUS3);

   ////////////////////////////////////////////////////////////////////////
   // slew

   // the bus slew limiter overrides the general bit entirely
   assign drive.bus_slew_en = slew_sel; // R1
   assign drive.std_slew_en = !slew_sel && gen_slew; // R1 R2 R11

   ////////////////////////////////////////////////////////////////////////
   // pull-up

   // reserved code 11 enables nothing rather than guessing a strength
   assign drive.weak_pullup_en = pu_std && gen_wpu; // R4 R10
   assign drive.pullup_x2_en = pu_double; // R3
   assign drive.pullup_x10_en = pu_tenfold; // R3

   ////////////////////////////////////////////////////////////////////////
   // input threshold

   assign drive.std_schmitt_sel = th_std && gen_inlvl; // R6 R12
   assign drive.std_ttl_sel = th_std && !gen_inlvl; // R6 R12
   assign drive.bus_thresh_sel = th_bus; // R5
   assign drive.smbus2_sel = th_smbus2; // R5
   assign drive.smbus3_sel = th_smbus3; // R5

   // peripherals read the schmitt bus input whenever a bus threshold is on
   assign drive.bus_input_sel = !th_std; // R9

endmodule

// ==== shared/pad_ctrl_pkg.sv ====
package pad_ctrl_pkg;

   typedef enum logic [1:0] {
      PU_STANDARD = 2'b00,
      PU_DOUBLE = 2'b01,
      PU_TENFOLD = 2'b10,
      PU_RESERVED = 2'b11
   } pullup_sel_t;

   typedef enum logic [1:0] {
      TH_STANDARD = 2'b00,
      TH_BUS_PAD = 2'b01,
      TH_SMBUS2 = 2'b10,
      TH_SMBUS3 = 2'b11
   } thresh_sel_t;

   // analog pad controls for one pin
   typedef struct packed {
      logic bus_slew_en;
      logic std_slew_en;
      logic weak_pullup_en;
      logic pullup_x2_en;
      logic pullup_x10_en;
      logic std_schmitt_sel;
      logic std_ttl_sel;
      logic bus_thresh_sel;
      logic smbus2_sel;
      logic smbus3_sel;
      logic bus_input_sel;
   } pad_drive_t;

endpackage

// ==== shared/pad_ctrl_regs.svh ====
`ifndef PAD_CTRL_REGS_SVH
`define PAD_CTRL_REGS_SVH

// byte offsets of the six pad control registers
`define OFS_PORTB_PIN1 12'h000
`define OFS_PORTB_PIN2 12'h004
`define OFS_PORTC_PIN3 12'h008
`define OFS_PORTC_PIN4 12'h00C
`define OFS_PORTD_PIN0 12'h010
`define OFS_PORTD_PIN1 12'h014
// general per-pin control word: bit n of each field belongs to pad n
`define OFS_PIN_GENERAL 12'h018

// field positions inside a pad control register
`define SLEW_SEL_BIT 6
`define PULLUP_HI 5
`define PULLUP_LO 4
`define THRESH_HI 1
`define THRESH_LO 0
`define PAD_IMPL_MASK 8'h73
`define PAD_RESET 8'h00

// general word layout: three 6-bit fields
`define GEN_SLEW_LO 0
`define GEN_WPU_LO 8
`define GEN_INLVL_LO 16
`define GEN_RESET 32'h00000000

`endif

// ==== verif/pad_ctrl_assertions.sv ====
module pad_ctrl_assertions #(parameter int NUM_PADS = 6) (
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pad side
   input wire pad_ctrl_pkg::pad_drive_t pad_drive [NUM_PADS]
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire pad_ctrl_pkg::pad_drive_t d0 = pad_drive[0];
   ready_now_a: assert property (acc |-> pready) else $error("late ready");
   unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr) else $error("no err");
   mapped_ok_a: assert property (
      acc && paddr < 12'h01C && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad err");
   read_unimpl_a: assert property (
      acc && !pwrite && paddr < 12'h018 |-> (prdata & 32'hFFFFFF8C) == 32'h00000000)
      else $error("unimpl set");
   slew_write_a: assert property (
      acc && pwrite && paddr == 12'h000 |=> d0.bus_slew_en == $past(pwdata[6]))
      else $error("slew lost");
   bus_input_a: assert property (
      d0.bus_input_sel == !(d0.std_schmitt_sel || d0.std_ttl_sel)) else $error("bus input");
   slew_excl_a: assert property (d0.bus_slew_en |-> !d0.std_slew_en) else $error("slew");
   pullup_excl_a: assert property (!(d0.pullup_x2_en && d0.pullup_x10_en)) else $error("pu");
   thresh_one_a: assert property (
      $onehot({d0.std_schmitt_sel, d0.std_ttl_sel, d0.bus_thresh_sel, d0.smbus2_sel,
      d0.smbus3_sel})) else $error("thresh");
   hold_idle_a: assert property (!(acc && pwrite) |=> $stable(d0)) else $error("drift");
   cover property (acc && pwrite && paddr == 12'h000 && pwdata[6]);
   cover property (acc && pslverr);
   cover property (acc && !pwrite && paddr == 12'h018);
endmodule

// ==== verif/tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   pad_ctrl_pkg::pad_drive_t pad_drive [6];
   int err_total = 0, tests_run = 0;
   always #12.5 pclk = ~pclk;
   two_wire_pad_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_drive(pad_drive));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge keeps back-to-back calls from driving psel twice at once
      @(posedge pclk);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("FAIL %0t got %h want %h", $time, g, e);
      end
   endtask
   function automatic logic [10:0] want(input logic [7:0] r, input logic [31:0] g, input int i);
      return {r[6], !r[6] && g[i], r[5:4] == 2'h0 && g[8+i], r[5:4] == 2'h1,
         r[5:4] == 2'h2, r[1:0] == 2'h0 && g[16+i], r[1:0] == 2'h0 && !g[16+i],
         r[1:0] == 2'h1, r[1:0] == 2'h2, r[1:0] == 2'h3, r[1:0] != 2'h0};
   endfunction
   task automatic complete_run();
      if (err_total == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   //////////////////////////////////////////////////
   initial
   begin
      #150us;
      err_total++;
      complete_run();
   end
   initial
   begin
      logic [7:0] v;
      logic [31:0] g;
      logic [10:0] m;
      int p;
      void'($urandom(32'h7db3));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // every code is written once, to pad k % 6 in turn; every pad control is judged
      for (int k = 0; k < 256; k++)
      begin
         p = k % 6;
         v = k[7:0];
         g = $urandom;
         m = 11'h7FF;
         apb(1'b1, 12'h018, g);
         apb(1'b0, 12'h018, 32'h00000000);
         chk(rd, g & 32'h003F3F3F);
         apb(1'b1, 12'(4 * p), {24'($urandom), v});
         apb(1'b0, 12'(4 * p), 32'h00000000);
         chk(rd, {24'h000000, v & 8'h73});
         chk({21'h0, 11'(pad_drive[p]) & m}, {21'h0, want(v, g, p) & m});
      end
      apb(1'b1, 12'h01C, 32'hFFFFFFFF);
      chk({31'h0, er}, 32'h00000001);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int k = 0; k < 8; k++)
      begin
         apb(1'b0, 12'(4 * k), 32'h00000000);
         chk(rd, 32'h00000000);
      end
      complete_run();
   end
endmodule
bind two_wire_pad_control pad_ctrl_assertions #(.NUM_PADS(NUM_PADS)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_drive(pad_drive));
